/* pkg/wdbs_pkg.sv */
// Shared constants and types for the watchdog and bridge state block.
// Assumes a single 40 MHz system clock and byte-wide register accesses.
package wdbs_pkg;

  // Register addresses on the byte register port
  localparam logic [7:0] ADDR_CTRL   = 8'h08;  // Pin, pump and watchdog control
  localparam logic [7:0] ADDR_BRIDGE = 8'h09;  // Bridge 1 to 4 output state

  // Reset values and masks
  localparam logic [7:0] CTRL_RESET   = 8'h02;  // Long window selected
  localparam logic [7:0] BRIDGE_RESET = 8'h00;  // All bridges high impedance
  localparam logic [7:0] CTRL_MASK    = 8'h7f;  // Top bit is not held here
  localparam logic [7:0] READ_IDLE    = 8'h00;  // Unmapped address reads

  // Control register bit positions
  localparam int unsigned BIT_PIN_SEL = 6;  // Shared pin function
  localparam int unsigned BIT_PUMP_LO = 4;  // Pump mode, two bits
  localparam int unsigned BIT_WATCHDOG_ENABLE   = 3;  // Watchdog enable
  localparam int unsigned BIT_WD_MODE = 2;  // Watchdog fault mode
  localparam int unsigned BIT_WATCHDOG_WINDOW  = 1;  // Watchdog window
  localparam int unsigned BIT_WATCHDOG_RESTART  = 0;  // Watchdog restart toggle

  // Bridge geometry
  localparam int unsigned BRIDGES = 4;  // Bridges in this register
  localparam int unsigned FIELD_W = 2;  // Width of each state field

  // Pump mode codes
  localparam logic [1:0] PUMP_AUTO    = 2'h0;
  localparam logic [1:0] PUMP_DOUBLER = 2'h1;
  localparam logic [1:0] PUMP_TRIPLER = 2'h2;

  // Bridge state codes
  localparam logic [1:0] BR_HIZ  = 2'h0;  // Both gates pulled down
  localparam logic [1:0] BR_LOW  = 2'h1;  // Low side on
  localparam logic [1:0] BR_HIGH = 2'h2;  // High side on
  localparam logic [1:0] BR_PWM  = 2'h3;  // Follow mapped PWM input

  // Watchdog window times in ms and their cycle counts
  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned WD_SHORT_MIN_MS = 4;
  localparam int unsigned WD_SHORT_MAX_MS = 40;
  localparam int unsigned WD_LONG_MIN_MS  = 10;
  localparam int unsigned WD_LONG_MAX_MS  = 100;
  localparam int unsigned WD_SHORT_MIN_CYC = WD_SHORT_MIN_MS * CLK_KHZ;  // Least: exact
  localparam int unsigned WD_SHORT_MAX_CYC = WD_SHORT_MAX_MS * CLK_KHZ;  // Longest: exact
  localparam int unsigned WD_LONG_MIN_CYC  = WD_LONG_MIN_MS * CLK_KHZ;
  localparam int unsigned WD_LONG_MAX_CYC  = WD_LONG_MAX_MS * CLK_KHZ;
  localparam int unsigned WD_CNT_W = 22;  // Holds the longest count

  // Watchdog states, one-hot
  typedef enum logic [1:0] {
    WD_IDLE = 2'h1,
    WD_RUN  = 2'h2
  } wdbs_wd_state_t;

endpackage : wdbs_pkg

/* core/wdbs_bridge.sv */
// One half-bridge gate output stage with registered gate levels.
// Assumes the PWM level is already selected and synchronous to the clock.
`timescale 1ns/1ps
module wdbs_bridge (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  // Control
  input  wire logic [1:0] state_in,       // Bridge state field
  input  wire logic       pwm_in,         // Mapped PWM level
  input  wire logic       side_in,        // 1: PWM drives high side
  input  wire logic       freewheel_in,   // 1: active freewheel
  input  wire logic       force_off_in,   // Global disable
  // Gates, 1 = pullup, 0 = pulldown
  output logic            high_gate_out,
  output logic            low_gate_out
);

  logic pwm_hi;  // PWM gate levels
  logic pwm_lo;
  logic hi_next;
  logic lo_next;

  // PWM on drives the chosen side; off either freewheels actively or floats
  assign pwm_hi = side_in ? pwm_in : (!pwm_in && freewheel_in);
  assign pwm_lo = side_in ? (!pwm_in && freewheel_in) : pwm_in;

  // State decode; disable wins so a fault never leaves a gate up
  always_comb begin
    hi_next = 1'b0;
    lo_next = 1'b0;
    if (!force_off_in) begin
      unique case (state_in)
        wdbs_pkg::BR_HIZ: begin
          hi_next = 1'b0;
          lo_next = 1'b0;
        end
        wdbs_pkg::BR_LOW: begin
          lo_next = 1'b1;
        end
        wdbs_pkg::BR_HIGH: begin
          hi_next = 1'b1;
        end
        wdbs_pkg::BR_PWM: begin
          hi_next = pwm_hi;
          lo_next = pwm_lo;
        end
      endcase
    end
  end

  // Gate registers
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_gate_out <= 1'b0;
      low_gate_out  <= 1'b0;
    end else begin
      high_gate_out <= hi_next;
      low_gate_out  <= lo_next;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_hiz;
    state_in == wdbs_pkg::BR_HIZ |=> !high_gate_out && !low_gate_out;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz state drove a gate");

  property p_low;
    state_in == wdbs_pkg::BR_LOW && !force_off_in |=> !high_gate_out && low_gate_out;
  endproperty
  a_low: assert property (p_low) else $error("low state gates wrong");

  property p_high;
    state_in == wdbs_pkg::BR_HIGH && !force_off_in |=> high_gate_out && !low_gate_out;
  endproperty
  a_high: assert property (p_high) else $error("high state gates wrong");

  property p_pwm;
    state_in == wdbs_pkg::BR_PWM && !force_off_in && side_in && pwm_in
      |=> high_gate_out && !low_gate_out;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm high side not followed");

endmodule : wdbs_bridge

/* core/wdbs_watchdog.sv */
// Window watchdog timer: flags toggles that come too early or too late.
// Assumes restart_in is a one-cycle pulse from the register write logic.
`timescale 1ns/1ps
module wdbs_watchdog #(
  parameter int unsigned SHORT_MIN = wdbs_pkg::WD_SHORT_MIN_CYC,
  parameter int unsigned SHORT_MAX = wdbs_pkg::WD_SHORT_MAX_CYC,
  parameter int unsigned LONG_MIN  = wdbs_pkg::WD_LONG_MIN_CYC,
  parameter int unsigned LONG_MAX  = wdbs_pkg::WD_LONG_MAX_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  // Control
  input  wire logic enable_in,       // Timer runs while high
  input  wire logic window_long_in,  // 1: long window
  input  wire logic restart_in,      // Toggle seen, pulse
  // Event
  output logic      fault_evt_out    // Window violated, pulse
);

  localparam int unsigned W = wdbs_pkg::WD_CNT_W;

  wdbs_pkg::wdbs_wd_state_t state_reg;   // Timer state
  wdbs_pkg::wdbs_wd_state_t state_next;
  logic [W-1:0]             cnt_reg;     // Cycles since restart
  logic [W-1:0]             cnt_next;
  logic [W-1:0]             min_cyc;     // Window bounds
  logic [W-1:0]             max_cyc;
  logic                     running;
  logic                     early;
  logic                     late;

  // Window select
  assign min_cyc = window_long_in ? W'(LONG_MIN) : W'(SHORT_MIN);
  assign max_cyc = window_long_in ? W'(LONG_MAX) : W'(SHORT_MAX);
  assign running = (state_reg == wdbs_pkg::WD_RUN) && enable_in;
  assign early   = running && restart_in && (cnt_reg < min_cyc);
  assign late    = running && !restart_in && (cnt_reg == max_cyc - W'(1));

  // State and count; a late timeout restarts the count for the next window
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      wdbs_pkg::WD_IDLE: begin
        cnt_next = '0;
        if (enable_in) begin
          state_next = wdbs_pkg::WD_RUN;
        end
      end
      wdbs_pkg::WD_RUN: begin
        if (!enable_in) begin
          state_next = wdbs_pkg::WD_IDLE;
          cnt_next   = '0;
        end else if (restart_in || late) begin
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + W'(1);
        end
      end
      default: begin  // Illegal code recovers to idle
        state_next = wdbs_pkg::WD_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg     <= wdbs_pkg::WD_IDLE;
      cnt_reg       <= '0;
      fault_evt_out <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      fault_evt_out <= early || late;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_off;
    !enable_in |=> !fault_evt_out;
  endproperty
  a_off: assert property (p_off) else $error("fault while watchdog off");

  property p_early;
    running && restart_in && cnt_reg < min_cyc |=> fault_evt_out;
  endproperty
  a_early: assert property (p_early) else $error("early toggle not flagged");

  property p_ok;
    running && restart_in && cnt_reg >= min_cyc |=> !fault_evt_out && cnt_reg == '0;
  endproperty
  a_ok: assert property (p_ok) else $error("good toggle mishandled");

  property p_late;
    running && !restart_in && cnt_reg == max_cyc - W'(1) |=> fault_evt_out;
  endproperty
  a_late: assert property (p_late) else $error("timeout not flagged");

endmodule : wdbs_watchdog

/* core/wdbs_ctrl.sv */
// Control register bank: shared pin, charge pump mode, window watchdog,
// and output state of half-bridges 1 to 4.
// Assumes the serial interface decodes frames into single-cycle byte
// register strobes, and that PWM inputs and the shared pin are synchronous.
`timescale 1ns/1ps

// Behaviour
// - Pin select: 0 driver disable, 1 fault output
// - Pump mode: auto, doubler, tripler, reserved
// - Watchdog timer runs only while enabled
// - Mode 0: flag and warning only
// - Mode 1: fault status, pin, drivers off
// - Watchdog fault latched until clear command
// - Window bit: 0 short, 1 long window
// - Inverting restart bit restarts timer, reads back
// - Four bridge fields, bridge 1 on top
// - State 00: both gates pulled down
// - State 01: low gate up, high down
// - State 10: high gate up, low down
// - State 11: gates follow mapped PWM input
// - Clear command clears latched faults, self-returns
module wdbs_ctrl #(
  parameter int unsigned WD_SHORT_MIN = wdbs_pkg::WD_SHORT_MIN_CYC,
  parameter int unsigned WD_SHORT_MAX = wdbs_pkg::WD_SHORT_MAX_CYC,
  parameter int unsigned WD_LONG_MIN  = wdbs_pkg::WD_LONG_MIN_CYC,
  parameter int unsigned WD_LONG_MAX  = wdbs_pkg::WD_LONG_MAX_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  // Byte register port from the serial interface
  input  wire logic [7:0] reg_addr_in,       // Register address
  input  wire logic [7:0] reg_wdata_in,      // Write data
  input  wire logic       reg_wr_in,         // Write strobe, pulse
  input  wire logic       reg_rd_in,         // Read strobe, pulse
  output logic [7:0]      reg_rdata_out,     // Read data, next cycle
  // Clear-faults command
  input  wire logic       clear_faults_in,   // Pulse
  // PWM mapping inputs
  input  wire logic [3:0] pwm_in,            // PWM input pins
  input  wire logic [7:0] bridge_pwm_source_in,  // 2 bits per bridge
  input  wire logic [3:0] bridge_side_select_in, // Bit 3 is bridge 1
  input  wire logic [3:0] bridge_freewheel_in,   // Bit 3 is bridge 1
  // Shared pin, open drain when used as fault output
  input  wire logic       shared_pin_in,     // Pin level, high disables
  output logic            shared_pin_out,    // Driven level
  output logic            shared_pin_oe_out, // High while pulling low
  // Fault reporting
  output logic            fault_pin_n_out,   // Active low fault pin
  output logic            watchdog_fault_flag_out,
  output logic            warning_status_out,
  output logic            fault_status_out,
  output logic            drivers_disabled_out,
  // Charge pump mode
  output logic            pump_auto_out,
  output logic            pump_doubler_out,
  output logic            pump_tripler_out,
  // Gate outputs, bit 3 is bridge 1, 1 = pullup
  output logic [3:0]      high_gate_output_out,
  output logic [3:0]      low_gate_output_out
);

  // Field of one bridge; bridge 1 sits in the top pair of bits
  function automatic logic [1:0] wdbs_field(input logic [7:0] v, input int unsigned b);
    wdbs_field = v[(wdbs_pkg::BRIDGES - 1 - b) * wdbs_pkg::FIELD_W +: wdbs_pkg::FIELD_W];
  endfunction : wdbs_field

  logic [7:0] ctrl_reg;           // Pin, pump, watchdog control
  logic [7:0] ctrl_next;
  logic [7:0] bridge_reg;         // Bridge state fields
  logic [7:0] bridge_next;
  logic       wd_fault_reg;       // Latched watchdog fault
  logic       wd_fault_next;
  logic [7:0] rdata_next;

  logic       wr_ctrl;            // Decoded strobes
  logic       wr_bridge;
  logic       restart_pulse;      // Toggle written
  logic       wd_fault_evt;       // From timer
  logic       pin_sel;            // Decoded control fields
  logic [1:0] pump_mode;
  logic       wd_enable;
  logic       wd_mode;
  logic       wd_window;
  logic       wd_restart;
  logic       fault_reported;     // Fault reaches fault status and pin
  logic       ext_disable;        // Shared pin as disable input
  logic       force_off;          // All gates down
  logic [3:0] hi_gate;            // From bridge stages
  logic [3:0] lo_gate;

  // Address decode and field extraction
  assign wr_ctrl    = reg_wr_in && (reg_addr_in == wdbs_pkg::ADDR_CTRL);
  assign wr_bridge  = reg_wr_in && (reg_addr_in == wdbs_pkg::ADDR_BRIDGE);
  assign pin_sel    = ctrl_reg[wdbs_pkg::BIT_PIN_SEL];
  assign pump_mode  = ctrl_reg[wdbs_pkg::BIT_PUMP_LO +: 2];
  assign wd_enable  = ctrl_reg[wdbs_pkg::BIT_WATCHDOG_ENABLE];
  assign wd_mode    = ctrl_reg[wdbs_pkg::BIT_WD_MODE];
  assign wd_window  = ctrl_reg[wdbs_pkg::BIT_WATCHDOG_WINDOW];
  assign wd_restart = ctrl_reg[wdbs_pkg::BIT_WATCHDOG_RESTART];

  // A write that inverts the stored restart bit is the restart toggle
  assign restart_pulse = wr_ctrl &&
    (reg_wdata_in[wdbs_pkg::BIT_WATCHDOG_RESTART] != wd_restart);

  // Register next values; the restart bit simply stores what was written
  assign ctrl_next   = wr_ctrl ? (reg_wdata_in & wdbs_pkg::CTRL_MASK) : ctrl_reg;
  assign bridge_next = wr_bridge ? reg_wdata_in : bridge_reg;

  // Fault latch: a new event wins over a clear in the same cycle
  assign wd_fault_next = wd_fault_evt ? 1'b1 :
                         clear_faults_in ? 1'b0 : wd_fault_reg;

  // Fault reaction depends on the current mode bit
  assign fault_reported = wd_fault_reg && wd_mode;
  assign ext_disable    = !pin_sel && shared_pin_in;
  assign force_off      = ext_disable || fault_reported;

  // Read mux; unmapped addresses read zero
  assign rdata_next = !reg_rd_in ? reg_rdata_out :
                      (reg_addr_in == wdbs_pkg::ADDR_CTRL)   ? ctrl_reg :
                      (reg_addr_in == wdbs_pkg::ADDR_BRIDGE) ? bridge_reg :
                      wdbs_pkg::READ_IDLE;

  // Open drain: the pin is only ever pulled low, never driven high
  assign shared_pin_out = 1'b0;

  // Control and bridge registers
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg   <= wdbs_pkg::CTRL_RESET;
      bridge_reg <= wdbs_pkg::BRIDGE_RESET;
    end else begin
      ctrl_reg   <= ctrl_next;
      bridge_reg <= bridge_next;
    end
  end

  // Fault latch and read data
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wd_fault_reg  <= 1'b0;
      reg_rdata_out <= wdbs_pkg::READ_IDLE;
    end else begin
      wd_fault_reg  <= wd_fault_next;
      reg_rdata_out <= rdata_next;
    end
  end

  // Fault reporting outputs, one cycle behind the latch
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watchdog_fault_flag_out <= 1'b0;
      warning_status_out      <= 1'b0;
      fault_status_out        <= 1'b0;
      fault_pin_n_out         <= 1'b1;
      shared_pin_oe_out       <= 1'b0;
      drivers_disabled_out    <= 1'b0;
    end else begin
      watchdog_fault_flag_out <= wd_fault_reg;
      warning_status_out      <= wd_fault_reg && !wd_mode;
      fault_status_out        <= fault_reported;
      fault_pin_n_out         <= !fault_reported;
      shared_pin_oe_out       <= pin_sel && fault_reported;
      drivers_disabled_out    <= force_off;
    end
  end

  // Pump mode decode; the reserved code falls back to automatic switching
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pump_auto_out    <= 1'b1;
      pump_doubler_out <= 1'b0;
      pump_tripler_out <= 1'b0;
    end else begin
      pump_doubler_out <= (pump_mode == wdbs_pkg::PUMP_DOUBLER);
      pump_tripler_out <= (pump_mode == wdbs_pkg::PUMP_TRIPLER);
      pump_auto_out    <= (pump_mode != wdbs_pkg::PUMP_DOUBLER) &&
                          (pump_mode != wdbs_pkg::PUMP_TRIPLER);
    end
  end

  // Window watchdog timer
  wdbs_watchdog #(
    .SHORT_MIN (WD_SHORT_MIN),
    .SHORT_MAX (WD_SHORT_MAX),
    .LONG_MIN  (WD_LONG_MIN),
    .LONG_MAX  (WD_LONG_MAX)
  ) u_watchdog (
    .sys_clk_in     (sys_clk_in),
    .arst_n_in      (arst_n_in),
    .enable_in      (wd_enable),
    .window_long_in (wd_window),
    .restart_in     (restart_pulse),
    .fault_evt_out  (wd_fault_evt)
  );

  // One gate stage per bridge; bit 3 of each vector is bridge 1
  for (genvar b = 0; b < wdbs_pkg::BRIDGES; b++) begin : g_bridge
    localparam int unsigned BIT = wdbs_pkg::BRIDGES - 1 - b;
    logic [1:0] src;  // Mapped PWM input index
    assign src = wdbs_field(bridge_pwm_source_in, b);
    wdbs_bridge u_bridge (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .state_in      (wdbs_field(bridge_reg, b)),
      .pwm_in        (pwm_in[src]),
      .side_in       (bridge_side_select_in[BIT]),
      .freewheel_in  (bridge_freewheel_in[BIT]),
      .force_off_in  (force_off),
      .high_gate_out (hi_gate[BIT]),
      .low_gate_out  (lo_gate[BIT])
    );
  end

  assign high_gate_output_out = hi_gate;
  assign low_gate_output_out  = lo_gate;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Event latched then reported two edges later
  sequence s_fault_latch;
    wd_fault_evt ##1 wd_fault_reg;
  endsequence

  property p_pin_input;
    !pin_sel && shared_pin_in |=> drivers_disabled_out && !shared_pin_oe_out;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin disable ignored");

  property p_pump;
    pump_mode == wdbs_pkg::PUMP_TRIPLER |=> pump_tripler_out && !pump_auto_out;
  endproperty
  a_pump: assert property (p_pump) else $error("pump decode wrong");

  property p_mode0;
    s_fault_latch ##0 !wd_mode |=> warning_status_out && fault_pin_n_out && !fault_status_out;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 report wrong");

  property p_mode1;
    s_fault_latch ##0 wd_mode |=> !fault_pin_n_out && drivers_disabled_out && fault_status_out;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 report wrong");

  property p_hold;
    wd_fault_reg && !clear_faults_in |=> wd_fault_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped without clear");

  property p_clear;
    clear_faults_in && !wd_fault_evt |=> !wd_fault_reg ##1 !watchdog_fault_flag_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear");

  property p_toggle;
    wr_ctrl && reg_wdata_in[wdbs_pkg::BIT_WATCHDOG_RESTART] != wd_restart
      |=> wd_restart == $past(reg_wdata_in[wdbs_pkg::BIT_WATCHDOG_RESTART]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("restart bit not stored");

  property p_bridge1;
    wr_bridge && reg_wdata_in[7:6] == wdbs_pkg::BR_HIGH && !force_off ##1 !force_off
      |=> high_gate_output_out[3] && !low_gate_output_out[3];
  endproperty
  a_bridge1: assert property (p_bridge1) else $error("bridge 1 field misplaced");

endmodule : wdbs_ctrl

/* sim/wdbs_mcu_model.sv */
// Controller model on the byte register port of the control bank.
// Assumes one clock; requests start 1 ns after a rising edge.
`timescale 1ns/1ps
module wdbs_mcu_model (
  // Clock
  input  wire logic       sys_clk_in,
  // Register port
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in,
  // Clear command
  output logic            clear_faults_out
);
  logic [7:0] ctrl_shadow = 8'h02;  // Last control byte sent

  // Idle port at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    clear_faults_out = 1'b0;
  end

  // One write; released lines show the inverse so stale data is never reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    if (a == wdbs_pkg::ADDR_CTRL) ctrl_shadow = d;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  // One read; data lands on the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    d = reg_rdata_in;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
  endtask : rd

  // Watchdog restart by inverting the stored restart bit
  task automatic kick;
    wr(wdbs_pkg::ADDR_CTRL, ctrl_shadow ^ 8'h01);
  endtask : kick

  // Clear-faults command, returns to 0 by itself
  task automatic clr;
    @(posedge sys_clk_in);
    #1;
    clear_faults_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    clear_faults_out = 1'b0;
  endtask : clr
endmodule : wdbs_mcu_model

/* sim/watchdog_and_bridge_state_ctrl_tb.sv */
// Self-checking bench for the watchdog and bridge state control bank.
// Assumes the controller model owns the register port and clear pulse.
`timescale 1ns/1ps
module watchdog_and_bridge_state_ctrl_tb;
  logic       sys_clk_in = 1'b0;  // 40 MHz
  logic       arst_n_in  = 1'b0;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic [7:0] src        = 8'h1b;  // Bridge n takes source n-1
  logic       wr, rd, clr, pa, pd, pt, spo;
  logic       pin        = 1'b0;
  logic [3:0] pwm        = 4'h5;
  logic [3:0] side       = 4'ha;
  logic [3:0] fw         = 4'h1;  // Only bridge 4 freewheels; no PWM bridge without freewheel sees PWM off, so the floating case is not seen
  logic [3:0] hg, lg;
  logic       flag, warn, flt, pin_n, dis, oe;
  logic [7:0] vals [4]   = '{8'h1b, 8'he4, 8'h80, 8'h1b};
  logic [3:0] pats [4]   = '{4'h5, 4'h3, 4'h5, 4'hc};  // Bridge 4 sees both PWM levels, bridge 1 only the high level
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cyc        = 0;
  wire  [7:0] st         = {1'b0, spo, flag, warn, flt, pin_n, dis, oe};  // Open drain level must stay 0

  // Short windows keep the run brief
  wdbs_ctrl #(.WD_SHORT_MIN(8), .WD_SHORT_MAX(40), .WD_LONG_MIN(20), .WD_LONG_MAX(100)) uut (
    .sys_clk_in, .arst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .clear_faults_in(clr),
    .pwm_in(pwm), .bridge_pwm_source_in(src), .bridge_side_select_in(side),
    .bridge_freewheel_in(fw), .shared_pin_in(pin), .shared_pin_out(spo),
    .shared_pin_oe_out(oe), .fault_pin_n_out(pin_n), .watchdog_fault_flag_out(flag),
    .warning_status_out(warn), .fault_status_out(flt), .drivers_disabled_out(dis),
    .pump_auto_out(pa), .pump_doubler_out(pd), .pump_tripler_out(pt),
    .high_gate_output_out(hg), .low_gate_output_out(lg));

  wdbs_mcu_model m (.sys_clk_in, .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .clear_faults_out(clr));

  // Clock
  always #12.5 sys_clk_in = ~sys_clk_in;

  // Hang guard, well above the expected run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  // Expected gates {high, low} from the state byte, bridge 1 on top
  function automatic logic [7:0] gates(input logic [7:0] s);
    logic [7:0] g;
    logic       p;
    g = 8'h00;
    for (int i = 0; i < 4; i++) begin
      p = pwm[src[7-2*i -: 2]];
      case (s[7-2*i -: 2])
        2'h1: g[3-i] = 1'b1;
        2'h2: g[7-i] = 1'b1;
        2'h3: {g[7-i], g[3-i]} = side[3-i] ? {p, !p & fw[3-i]} : {!p & fw[3-i], p};
        default: ;
      endcase
    end
    return g;
  endfunction : gates

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Let register and output stages settle
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : wait_n

  // Verdict
  task automatic results;
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1;
    arst_n_in = 1'b1;
    m.rd(8'h08, rd_v);
    chk(rd_v, 8'h02);
    m.rd(8'h09, rd_v);
    chk(rd_v, 8'h00);
    m.rd(8'h0a, rd_v);
    chk(rd_v, 8'h00);
    chk(st, 8'h04);
    for (int k = 0; k < 4; k++) begin
      m.wr(8'h08, 8'(k) << 4);
      wait_n(3);
      chk({5'h00, pa, pd, pt}, (k == 1) ? 8'h02 : (k == 2) ? 8'h01 : 8'h04);
    end
    m.wr(8'h08, 8'hf0);
    m.rd(8'h08, rd_v);
    chk(rd_v, 8'h70);
    pin = 1'b1;
    foreach (vals[j]) begin
      pwm = pats[j];
      m.wr(8'h09, vals[j]);
      wait_n(3);
      chk({hg, lg}, gates(vals[j]));
    end
    m.rd(8'h09, rd_v);
    chk(rd_v, 8'h1b);
    m.wr(8'h08, 8'h00);
    wait_n(3);
    chk({hg, lg}, 8'h00);
    chk(st, 8'h06);
    pin = 1'b0;
    m.wr(8'h08, 8'h08);
    wait_n(20);
    m.kick();
    wait_n(3);
    chk(st, 8'h04);
    m.rd(8'h08, rd_v);
    chk(rd_v, 8'h09);
    wait_n(50);
    chk(st, 8'h34);
    chk({hg, lg}, gates(8'h1b));
    m.clr();
    wait_n(3);
    chk(st, 8'h04);
    m.wr(8'h08, 8'h41);
    m.clr();
    m.wr(8'h08, 8'h4f);
    wait_n(12);
    m.kick();
    wait_n(5);
    chk(st, 8'h2b);
    chk({hg, lg}, 8'h00);
    m.wr(8'h08, 8'h44);
    wait_n(20);
    chk(st, 8'h2b);
    m.clr();
    wait_n(200);
    chk(st, 8'h04);
    results();
  end
endmodule : watchdog_and_bridge_state_ctrl_tb
